// ==== rtl/link_status_pkg.sv ====
// Package: function codes, status layout and carriers for the status select block
package link_status_pkg;
   localparam int           FUNC_W          = 12;
   localparam logic [5:0]   FUNC_MASTER     = 6'h1E;  // Leading octal digits 3 and 6
   localparam logic [2:0]   FN_STOP_SEND    = 3'h0;
   localparam logic [2:0]   FN_SEND         = 3'h1;
   localparam logic [2:0]   FN_SEL_DATA     = 3'h2;
   localparam logic [2:0]   FN_SEL_STATUS   = 3'h3;
   localparam logic [2:0]   FN_INT_OFF      = 3'h4;
   localparam logic [2:0]   FN_INT_ON       = 3'h5;
   localparam int           STAT_W          = 12;
   localparam int           ST_LOCAL_SEND   = 0;
   localparam int           ST_REMOTE_SEND  = 1;
   localparam int           ST_OUT_WANTED   = 2;
   localparam int           ST_IN_WAITING   = 3;
   localparam logic [2:0]   UNIT_RESET      = 3'h0;

   typedef enum logic [1:0] {
      SEL_NONE   = 2'h0,
      SEL_DATA   = 2'h1,
      SEL_STATUS = 2'h3
   } sel_t;

   typedef struct packed {
      logic cts;
      logic carrier;
      logic remote_send;
   } modem_t;

   typedef struct packed {
      logic send_lamp;
      logic recv_lamp;
   } lamp_t;
endpackage

// ==== rtl/link_status_select.sv ====
// Status select, status word and lamp logic of the data set controller
//
// Summary of operation
// - Send mode: input selection works as in receive
// - Repeated status requests in send ignored
// - Receive mode: request routes status, drops data
// - No mode: request handled as in send
// - Status in the four lowest bits
// - Bit 0 is local send mode
// - Bit 1 is remote send mode
// - Bit 2 only in send, output wanted
// - Bit 2 clears on output, resets later
// - Bit 3 is bit 1 and word waiting
// - Bit 3 clears on data input, sets again
// - Send lamp: local send and clear-to-send
// - Receive lamp: remote send and carrier
// - Data or status selection persists until swapped
// - Send cleared by stop or master clear
// - Act only on matching unit digit
`timescale 1ns/1ps
module link_status_select #(
   parameter logic [2:0] UNIT = link_status_pkg::UNIT_RESET
) (
   input  wire logic                                I_REF_CLK,
   input  wire logic                                I_RST_N,
   input  wire logic                                i_func_valid,
   input  wire logic [link_status_pkg::FUNC_W-1:0]  i_func_code,
   input  wire logic                                i_master_clear,
   input  wire logic                                i_host_input,
   input  wire logic                                i_host_output,
   input  wire logic                                i_tx_ready,
   input  wire logic                                i_rx_word_ready,
   input  wire link_status_pkg::modem_t             i_modem,
   output logic [link_status_pkg::STAT_W-1:0]       o_in_word,
   output logic                                     o_status_sel,
   output logic                                     o_data_sel,
   output logic                                     o_int_enable,
   output link_status_pkg::lamp_t                   o_lamp
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: a change counts once stages two and three agree
   logic [2:0] s1;
   logic [2:0] s2;
   logic [2:0] s3;
   logic [2:0] pin;
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         s1  <= 3'h0;
         s2  <= 3'h0;
         s3  <= 3'h0;
         pin <= 3'h0;
      end else begin
         s1 <= i_modem;
         s2 <= s1;
         s3 <= s2;
         for (int k = 0; k < 3; k++) begin
            if (s2[k] == s3[k]) begin
               pin[k] <= s3[k];
            end
         end
      end
   end
   logic cts;
   logic carrier;
   logic remote_send;
   assign cts         = pin[2];
   assign carrier     = pin[1];
   assign remote_send = pin[0];

   ////////////////////////////////////////////////////////////////////////////
   // Function decode
   logic       hit;
   logic [2:0] fn;
   assign hit = i_func_valid && i_func_code[11:6] == link_status_pkg::FUNC_MASTER
                && i_func_code[5:3] == UNIT;
   assign fn  = i_func_code[2:0];

   logic send_mode;
   logic int_en;
   link_status_pkg::sel_t sel;

   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         send_mode <= 1'b0;
      end else if (i_master_clear) begin
         send_mode <= 1'b0;
      end else if (hit && fn == link_status_pkg::FN_SEND) begin
         send_mode <= 1'b1;
      end else if (hit && fn == link_status_pkg::FN_STOP_SEND) begin
         send_mode <= 1'b0;
      end
   end

   // Interrupt selection survives master clear and stop
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         int_en <= 1'b1;
      end else if (hit && fn == link_status_pkg::FN_INT_OFF) begin
         int_en <= 1'b0;
      end else if (hit && fn == link_status_pkg::FN_INT_ON) begin
         int_en <= 1'b1;
      end
   end

   // Input selection: status request in receive drops data selection
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sel <= link_status_pkg::SEL_NONE;
      end else if (hit && fn == link_status_pkg::FN_SEL_DATA) begin
         sel <= link_status_pkg::SEL_DATA;
      end else if (hit && fn == link_status_pkg::FN_SEL_STATUS) begin
         sel <= link_status_pkg::SEL_STATUS;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags: set wins over strobe clear
   logic out_wanted;
   logic in_waiting;
   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         out_wanted <= 1'b0;
      end else if (!send_mode) begin
         out_wanted <= 1'b0;
      end else if (i_tx_ready) begin
         out_wanted <= 1'b1;
      end else if (i_host_output) begin
         out_wanted <= 1'b0;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         in_waiting <= 1'b0;
      end else if (i_rx_word_ready) begin
         in_waiting <= 1'b1;
      end else if (i_host_input && sel == link_status_pkg::SEL_DATA) begin
         in_waiting <= 1'b0;
      end
   end

   logic [link_status_pkg::STAT_W-1:0] next_status;
   always_comb begin
      next_status                                  = '0;
      next_status[link_status_pkg::ST_LOCAL_SEND]  = send_mode;
      next_status[link_status_pkg::ST_REMOTE_SEND] = remote_send;
      next_status[link_status_pkg::ST_OUT_WANTED]  = out_wanted & send_mode;
      next_status[link_status_pkg::ST_IN_WAITING]  = remote_send & in_waiting;
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         o_in_word <= '0;
         o_lamp    <= '0;
      end else begin
         o_in_word        <= next_status;
         o_lamp.send_lamp <= send_mode & cts;
         o_lamp.recv_lamp <= remote_send & carrier;
      end
   end

   assign o_status_sel = sel == link_status_pkg::SEL_STATUS;
   assign o_data_sel   = sel == link_status_pkg::SEL_DATA;
   assign o_int_enable = int_en;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence req_status;
      hit && fn == link_status_pkg::FN_SEL_STATUS;
   endsequence
   sequence status_kept;
      o_status_sel && !(hit && fn == link_status_pkg::FN_SEL_DATA);
   endsequence
   sequence data_kept;
      o_data_sel && !(hit && fn == link_status_pkg::FN_SEL_STATUS);
   endsequence
   sequence status_again;
      hit && fn == link_status_pkg::FN_SEL_STATUS && o_status_sel && !i_master_clear;
   endsequence
   // Flag clears reach the status word two edges after the strobe
   sequence output_taken;
      send_mode && i_host_output && !i_tx_ready;
   endsequence
   sequence input_taken;
      o_data_sel && i_host_input && !i_rx_word_ready;
   endsequence

   a_status_route: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      req_status |=> o_status_sel && !o_data_sel) else $error("status select missed");
   a_sel_persist: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      status_kept |=> o_status_sel) else $error("status select lost");
   a_data_persist: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      data_kept |=> o_data_sel) else $error("data select lost");
   a_status_repeat: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      status_again |=> o_status_sel && $stable(send_mode) && $stable(int_en))
      else $error("repeated status request acted");
   a_out_clear: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      output_taken |-> ##2 !o_in_word[link_status_pkg::ST_OUT_WANTED])
      else $error("output flag not cleared");
   a_in_clear: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      input_taken |-> ##2 !o_in_word[link_status_pkg::ST_IN_WAITING])
      else $error("input flag not cleared");
   a_stop_send: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      $fell(send_mode) |-> $past(i_master_clear)
      || $past(hit && fn == link_status_pkg::FN_STOP_SEND)) else $error("send dropped");
   a_unit_match: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      i_func_valid && i_func_code[5:3] != UNIT && !i_master_clear |=> $stable(send_mode))
      else $error("foreign unit acted");
   a_bit0_send: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      ##1 o_in_word[0] == $past(send_mode)) else $error("bit 0 wrong");
   a_bit2_only: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      o_in_word[2] |-> o_in_word[0]) else $error("bit 2 outside send");
   a_bit3_remote: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      o_in_word[3] |-> o_in_word[1]) else $error("bit 3 without bit 1");
   a_high_zero: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      o_in_word[11:4] == 8'h00) else $error("high status bits set");
   a_send_lamp: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      o_lamp.send_lamp |-> $past(send_mode) && $past(cts)) else $error("send lamp wrong");
   a_recv_lamp: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      ##1 o_lamp.recv_lamp == $past(remote_send && carrier)) else $error("recv lamp wrong");
endmodule

// ==== test/host_channel_model.sv ====
// Host parallel channel: function codes, input and output strobes
`timescale 1ns/1ps
module host_channel_model (
   input  wire logic        i_clk,
   output logic             o_func_valid,
   output logic [11:0]      o_func_code,
   output logic             o_host_input,
   output logic             o_host_output
);
   initial begin
      o_func_valid  = 1'b0;
      o_func_code   = 12'h000;
      o_host_input  = 1'b0;
      o_host_output = 1'b0;
   end

   // One code per call, held valid for one clock edge
   task automatic func(input logic [2:0] unit, input logic [2:0] fn);
      @(posedge i_clk);
      #1;
      o_func_valid = 1'b1;
      o_func_code  = {link_status_pkg::FUNC_MASTER, unit, fn};
      @(posedge i_clk);
      #1;
      o_func_valid = 1'b0;
      // Released lines do not keep the last code
      o_func_code  = ~o_func_code;
   endtask

   task automatic strobe(input logic out);
      @(posedge i_clk);
      #1;
      o_host_input  = ~out;
      o_host_output = out;
      @(posedge i_clk);
      #1;
      o_host_input  = 1'b0;
      o_host_output = 1'b0;
   endtask
endmodule

// ==== test/link_status_select_bench.sv ====
// Self-checking bench for the status select block
`timescale 1ns/1ps
module link_status_select_bench;
   localparam logic [2:0]   U = 3'h0;
   logic                    clk;
   logic                    rst_n;
   logic                    fv;
   logic [11:0]             fc;
   logic                    hin;
   logic                    hout;
   logic [2:0]              ctl;
   link_status_pkg::modem_t modem;
   logic [11:0]             word;
   logic                    ssel;
   logic                    dsel;
   logic                    inten;
   link_status_pkg::lamp_t  lamp;
   int                      fails;
   int                      tests_run;

   link_status_select #(.UNIT(U)) i_link_status_select (
      .I_REF_CLK(clk), .I_RST_N(rst_n), .i_func_valid(fv), .i_func_code(fc),
      .i_master_clear(ctl[2]), .i_host_input(hin), .i_host_output(hout),
      .i_tx_ready(ctl[1]), .i_rx_word_ready(ctl[0]), .i_modem(modem),
      .o_in_word(word), .o_status_sel(ssel), .o_data_sel(dsel),
      .o_int_enable(inten), .o_lamp(lamp));

   host_channel_model i_host_channel_model (
      .i_clk(clk), .o_func_valid(fv), .o_func_code(fc),
      .o_host_input(hin), .o_host_output(hout));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic ev(input logic [2:0] v);
      @(posedge clk);
      #1;
      ctl = v;
      @(posedge clk);
      #1;
      ctl = 3'h0;
   endtask

   task automatic settle();
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      #50000;
      fails++;
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      ctl = 3'h0;
      modem = '0;
      fails = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      check("word", word, 12'h000);
      check("sel", {ssel, dsel, inten, lamp}, 12'h004);
      modem = '{cts: 1'b1, carrier: 1'b1, remote_send: 1'b1};
      i_host_channel_model.func(U, 3'h3);
      settle();
      check("sel", {ssel, dsel}, 12'h002);
      check("word", word, 12'h002);
      check("lamp", lamp, 12'h001);
      i_host_channel_model.func(U, 3'h1);
      settle();
      check("word", word, 12'h001 | 12'h002);
      check("lamp", lamp, 12'h003);
      ev(3'h2);
      settle();
      check("word", word, 12'h007);
      i_host_channel_model.strobe(1'b1);
      settle();
      check("word", word, 12'h003);
      i_host_channel_model.func(U, 3'h3);
      i_host_channel_model.strobe(1'b0);
      settle();
      check("sel", {ssel, dsel}, 12'h002);
      check("word", word, 12'h003);
      i_host_channel_model.func(3'h5, 3'h0);
      settle();
      check("word", word, 12'h003);
      i_host_channel_model.func(U, 3'h2);
      settle();
      check("sel", {ssel, dsel}, 12'h001);
      ev(3'h1);
      settle();
      check("word", word, 12'h00B);
      i_host_channel_model.strobe(1'b0);
      settle();
      check("word", word, 12'h003);
      ev(3'h1);
      i_host_channel_model.func(U, 3'h3);
      settle();
      check("sel", {ssel, dsel}, 12'h002);
      check("word", word, 12'h00B);
      i_host_channel_model.strobe(1'b0);
      i_host_channel_model.func(U, 3'h2);
      settle();
      check("sel", {ssel, dsel}, 12'h001);
      check("word", word, 12'h00B);
      i_host_channel_model.func(U, 3'h0);
      settle();
      check("word", word, 12'h00A);
      check("int", inten, 12'h001);
      i_host_channel_model.func(U, 3'h1);
      ev(3'h4);
      settle();
      check("word", word, 12'h00A);
      i_host_channel_model.func(U, 3'h4);
      i_host_channel_model.func(U, 3'h0);
      ev(3'h4);
      settle();
      check("int", inten, 12'h000);
      i_host_channel_model.func(U, 3'h5);
      settle();
      check("int", inten, 12'h001);
      modem = '0;
      settle();
      check("word", word, 12'h000);
      check("lamp", lamp, 12'h000);
      test_done();
   end
endmodule
